/* File: core/htwrp_defs.svh */
`ifndef HTWRP_DEFS_SVH
`define HTWRP_DEFS_SVH

// Device side
`define HTWRP_ADDR_TOP 2'b00
`define HTWRP_SCAN_CONTROL 8'h62
`define HTWRP_TUNER_MASTER_BIT 3
`define HTWRP_PTR_RESET 8'h00
`define HTWRP_MEM_RESET 8'h00
`define HTWRP_BITS_PER_BYTE 4'd8
`define HTWRP_LAST_BIT 4'd7
`define HTWRP_STRAP_CAP 2'd2
`define HTWRP_STRAP_DONE 2'd3

// Host controller registers (byte addresses)
`define HTWRP_REG_CMD 8'h00
`define HTWRP_REG_TX 8'h04
`define HTWRP_REG_RX 8'h08
`define HTWRP_REG_STATUS 8'h0c
`define HTWRP_CMD_START 3'd1
`define HTWRP_CMD_STOP 3'd2
`define HTWRP_CMD_WRITE 3'd3
`define HTWRP_CMD_READ 3'd4
`define HTWRP_CMD_NACK_BIT 3
`define HTWRP_BUSY_BIT 0
`define HTWRP_NACK_BIT 1

// Host link timing
`define HTWRP_PCLK_HZ 100000000
`define HTWRP_LINK_HZ 400000
`define HTWRP_RESET_HOLD_MS 50

`endif

/* File: core/htwrp_pkg.sv */
package htwrp_pkg;

typedef enum logic [2:0] {
    HTWRP_DS_IDLE = 3'b000,
    HTWRP_DS_ADDR = 3'b001,
    HTWRP_DS_ADDR_ACK = 3'b010,
    HTWRP_DS_WR_BYTE = 3'b011,
    HTWRP_DS_WR_ACK = 3'b100,
    HTWRP_DS_RD_BYTE = 3'b101,
    HTWRP_DS_RD_ACK = 3'b110,
    HTWRP_DS_IGNORE = 3'b111
} htwrp_dev_state_e;

typedef enum logic [1:0] {
    HTWRP_OP_IDLE = 2'b00,
    HTWRP_OP_START = 2'b01,
    HTWRP_OP_STOP = 2'b10,
    HTWRP_OP_BYTE = 2'b11
} htwrp_host_op_e;

typedef logic [7:0] htwrp_byte_t;

endpackage

/* File: core/htwrp_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface htwrp_if;
    logic host_clk;
    logic host_data_out;
    logic host_data_oe_n;
    logic dev_data_out;
    logic dev_data_oe_n;
    logic data_line;

    // Open-drain data line with pull-up
    assign data_line = (host_data_oe_n | host_data_out) &
                       (dev_data_oe_n | dev_data_out);

    modport host (
        output host_clk,
        output host_data_out,
        output host_data_oe_n,
        input data_line
    );

    modport dev (
        output dev_data_out,
        output dev_data_oe_n,
        input host_clk,
        input data_line
    );
endinterface

`default_nettype wire

/* File: core/htwrp_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module htwrp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_ff;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b1;
                    q[i] <= 1'b1;
                end else begin
                    meta_ff <= d[i];
                    q[i] <= meta_ff;
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* File: core/htwrp_device.sv */
// Contract
// (RULE1) Bytes go most significant bit first
// (RULE2) Address top two bits zero, rest straps
// (RULE3) Straps latched as reset input rises
// (RULE4) Host holds reset low 50 ms
// (RULE5) Address lsb one reads, zero writes
// (RULE6) First written byte loads register pointer
// (RULE7) Pointer advances after every data byte
// (RULE8) Host avoids touching reserved register locations
// (RULE9) Stop after own transfer clears pointer
// (RULE10) Foreign address: ignore until own address
// (RULE11) Start keeps the register pointer
// (RULE12) Write after read continues without pointer
// (RULE13) Read after stop starts at register zero
// (RULE14) Scan control bit 3 enables tuner master
// (RULE15) Tuner clock output only, no stretching
`timescale 1ns/1ns
`default_nettype none
`include "htwrp_defs.svh"

module htwrp_device (
    input wire logic pclk,
    input wire logic presetn,
    htwrp_if.dev link,
    input wire logic [4:0] address_strap_inputs,
    input wire logic tuner_clk_src,
    input wire logic tuner_data_src,
    input wire logic [1:0] gp_out,
    input wire logic [1:0] gp_oe_n,
    input wire logic general_port_line_one_in,
    output logic general_port_line_zero_out,
    output logic general_port_line_zero_oe_n,
    output logic general_port_line_one_out,
    output logic general_port_line_one_oe_n,
    output logic tuner_data_in,
    output logic tuner_master_mode,
    output htwrp_pkg::htwrp_byte_t register_pointer,
    output logic [6:0] bus_address
);
    import htwrp_pkg::*;

    logic [2:0] pins_s;
    logic [4:0] strap_s;
    logic scl;
    logic sda;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [1:0] boot_cnt_ff;
    logic [4:0] strap_ff;
    htwrp_dev_state_e state_ff;
    logic [3:0] cnt_ff;
    htwrp_byte_t shift_ff;
    htwrp_byte_t ptr_ff;
    logic sda_low_ff;
    logic addressed_ff;
    logic read_seen_ff;
    logic want_ptr_ff;
    logic nack_ff;
    logic mem_we;
    htwrp_byte_t mem [256];

    htwrp_sync #(.WIDTH(3)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({general_port_line_one_in, link.data_line, link.host_clk}),
        .q(pins_s)
    );

    htwrp_sync #(.WIDTH(5)) u_strap_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(address_strap_inputs),
        .q(strap_s)
    );

    assign scl = pins_s[0];
    assign sda = pins_s[1];
    assign tuner_data_in = pins_s[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
        end
    end

    assign scl_rise = scl & ~scl_d_ff;
    assign scl_fall = ~scl & scl_d_ff;
    assign start_cond = scl & scl_d_ff & sda_d_ff & ~sda;
    assign stop_cond = scl & scl_d_ff & ~sda_d_ff & sda;

    // Straps need the synchroniser to fill before they are trusted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt_ff <= 2'd0;
        end else if (boot_cnt_ff != `HTWRP_STRAP_DONE) begin
            boot_cnt_ff <= boot_cnt_ff + 2'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_ff <= 5'h00;
        end else if (boot_cnt_ff == `HTWRP_STRAP_CAP) begin
            strap_ff <= strap_s; // RULE3
        end
    end

    assign bus_address = {`HTWRP_ADDR_TOP, strap_ff}; // RULE2
    assign register_pointer = ptr_ff;

    assign mem_we = (state_ff == HTWRP_DS_WR_BYTE) && scl_fall &&
                    (cnt_ff == `HTWRP_BITS_PER_BYTE) && !want_ptr_ff &&
                    !start_cond && !stop_cond;

    // Bus protocol engine; stop and start override any bit in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= HTWRP_DS_IDLE;
            cnt_ff <= 4'd0;
            shift_ff <= 8'h00;
            ptr_ff <= `HTWRP_PTR_RESET;
            sda_low_ff <= 1'b0;
            addressed_ff <= 1'b0;
            read_seen_ff <= 1'b0;
            want_ptr_ff <= 1'b0;
            nack_ff <= 1'b0;
        end else if (stop_cond) begin
            state_ff <= HTWRP_DS_IDLE;
            sda_low_ff <= 1'b0;
            addressed_ff <= 1'b0;
            read_seen_ff <= 1'b0;
            if (addressed_ff) begin
                ptr_ff <= `HTWRP_PTR_RESET; // RULE9 RULE13
            end
        end else if (start_cond) begin
            state_ff <= HTWRP_DS_ADDR; // RULE11
            cnt_ff <= 4'd0;
            sda_low_ff <= 1'b0;
        end else begin
            case (state_ff)
                HTWRP_DS_ADDR: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda}; // RULE1
                        cnt_ff <= cnt_ff + 4'd1;
                    end else if (scl_fall &&
                                 cnt_ff == `HTWRP_BITS_PER_BYTE) begin
                        if (shift_ff[7:1] == bus_address) begin
                            sda_low_ff <= 1'b1;
                            addressed_ff <= 1'b1;
                            state_ff <= HTWRP_DS_ADDR_ACK;
                            if (shift_ff[0]) begin
                                read_seen_ff <= 1'b1;
                            end else begin
                                want_ptr_ff <= ~read_seen_ff; // RULE12
                            end
                        end else begin
                            state_ff <= HTWRP_DS_IGNORE; // RULE10
                        end
                    end
                end
                HTWRP_DS_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_ff <= 4'd0;
                        if (shift_ff[0]) begin
                            shift_ff <= mem[ptr_ff]; // RULE5
                            sda_low_ff <= ~mem[ptr_ff][7];
                            state_ff <= HTWRP_DS_RD_BYTE;
                        end else begin
                            sda_low_ff <= 1'b0;
                            state_ff <= HTWRP_DS_WR_BYTE;
                        end
                    end
                end
                HTWRP_DS_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda}; // RULE1
                        cnt_ff <= cnt_ff + 4'd1;
                    end else if (scl_fall &&
                                 cnt_ff == `HTWRP_BITS_PER_BYTE) begin
                        sda_low_ff <= 1'b1;
                        cnt_ff <= 4'd0;
                        state_ff <= HTWRP_DS_WR_ACK;
                        if (want_ptr_ff) begin
                            ptr_ff <= shift_ff; // RULE6
                            want_ptr_ff <= 1'b0;
                        end else begin
                            ptr_ff <= ptr_ff + 8'h01; // RULE7
                        end
                    end
                end
                HTWRP_DS_WR_ACK: begin
                    if (scl_fall) begin
                        sda_low_ff <= 1'b0;
                        state_ff <= HTWRP_DS_WR_BYTE;
                    end
                end
                HTWRP_DS_RD_BYTE: begin
                    if (scl_fall) begin
                        if (cnt_ff == `HTWRP_LAST_BIT) begin
                            sda_low_ff <= 1'b0;
                            ptr_ff <= ptr_ff + 8'h01; // RULE7
                            state_ff <= HTWRP_DS_RD_ACK;
                        end else begin
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            sda_low_ff <= ~shift_ff[6]; // RULE1
                            cnt_ff <= cnt_ff + 4'd1;
                        end
                    end
                end
                HTWRP_DS_RD_ACK: begin
                    if (scl_rise) begin
                        nack_ff <= sda;
                    end else if (scl_fall) begin
                        cnt_ff <= 4'd0;
                        if (nack_ff) begin
                            state_ff <= HTWRP_DS_IGNORE;
                        end else begin
                            shift_ff <= mem[ptr_ff];
                            sda_low_ff <= ~mem[ptr_ff][7];
                            state_ff <= HTWRP_DS_RD_BYTE;
                        end
                    end
                end
                default: begin
                    sda_low_ff <= 1'b0;
                end
            endcase
        end
    end

    // Register space; reserved locations are guarded by software only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= `HTWRP_MEM_RESET;
            end
        end else if (mem_we) begin
            mem[ptr_ff] <= shift_ff;
        end
    end

    assign link.dev_data_out = 1'b0;
    assign link.dev_data_oe_n = ~sda_low_ff;

    assign tuner_master_mode =
        mem[`HTWRP_SCAN_CONTROL][`HTWRP_TUNER_MASTER_BIT]; // RULE14

    // Tuner clock is pushed, never released, so a slave cannot stretch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_port_line_zero_out <= 1'b0;
            general_port_line_zero_oe_n <= 1'b1;
            general_port_line_one_out <= 1'b0;
            general_port_line_one_oe_n <= 1'b1;
        end else if (tuner_master_mode) begin
            general_port_line_zero_out <= tuner_clk_src; // RULE14
            general_port_line_zero_oe_n <= 1'b0; // RULE15
            general_port_line_one_out <= 1'b0;
            general_port_line_one_oe_n <= tuner_data_src;
        end else begin
            general_port_line_zero_out <= gp_out[0];
            general_port_line_zero_oe_n <= gp_oe_n[0];
            general_port_line_one_out <= gp_out[1];
            general_port_line_one_oe_n <= gp_oe_n[1];
        end
    end
endmodule

`default_nettype wire

/* File: core/htwrp_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "htwrp_defs.svh"

module htwrp_host #(
    parameter int QUARTER = (`HTWRP_PCLK_HZ + 4 * `HTWRP_LINK_HZ - 1) /
                            (4 * `HTWRP_LINK_HZ)
) (
    input wire logic pclk,
    input wire logic presetn,
    htwrp_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import htwrp_pkg::*;

    logic [0:0] sda_s;
    logic cmd_wr;
    logic tick;
    logic [7:0] tick_cnt_ff;
    htwrp_host_op_e op_ff;
    logic rd_ff;
    logic nack_req_ff;
    logic [1:0] phase_ff;
    logic [3:0] bitn_ff;
    htwrp_byte_t tx_ff;
    htwrp_byte_t txsh_ff;
    htwrp_byte_t rxsh_ff;
    htwrp_byte_t rx_ff;
    logic nack_ff;
    logic clk_ff;
    logic sda_low_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic setup;
    logic mapped;

    htwrp_sync #(.WIDTH(1)) u_sda_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(link.data_line),
        .q(sda_s)
    );

    assign setup = psel & ~penable;
    assign mapped = paddr[7:0] == `HTWRP_REG_CMD ||
                    paddr[7:0] == `HTWRP_REG_TX ||
                    paddr[7:0] == `HTWRP_REG_RX ||
                    paddr[7:0] == `HTWRP_REG_STATUS;
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign cmd_wr = psel & penable & pwrite &
                    (paddr[7:0] == `HTWRP_REG_CMD) & (paddr[31:8] == 24'h0);

    // Read data is captured in the setup phase so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            pslverr_ff <= ~mapped | (paddr[31:8] != 24'h0);
            case (paddr[7:0])
                `HTWRP_REG_TX: prdata_ff <= {24'h0, tx_ff};
                `HTWRP_REG_RX: prdata_ff <= {24'h0, rx_ff};
                `HTWRP_REG_STATUS:
                    prdata_ff <= {30'h0, nack_ff, op_ff != HTWRP_OP_IDLE};
                default: prdata_ff <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ff <= 8'h00;
        end else if (psel && penable && pwrite &&
                     paddr == {24'h0, `HTWRP_REG_TX}) begin
            tx_ff <= pwdata[7:0];
        end
    end

    assign tick = (op_ff != HTWRP_OP_IDLE) &&
                  (tick_cnt_ff == 8'(QUARTER - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 8'h00;
        end else if (op_ff == HTWRP_OP_IDLE || tick) begin
            tick_cnt_ff <= 8'h00;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
    end

    // Each bit is four quarter periods: data, rise, sample, fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ff <= HTWRP_OP_IDLE;
            rd_ff <= 1'b0;
            nack_req_ff <= 1'b0;
            phase_ff <= 2'd0;
            bitn_ff <= 4'd0;
            txsh_ff <= 8'h00;
            rxsh_ff <= 8'h00;
            rx_ff <= 8'h00;
            nack_ff <= 1'b0;
            clk_ff <= 1'b1;
            sda_low_ff <= 1'b0;
        end else if (op_ff == HTWRP_OP_IDLE) begin
            phase_ff <= 2'd0;
            bitn_ff <= 4'd0;
            if (cmd_wr) begin
                rd_ff <= pwdata[2:0] == `HTWRP_CMD_READ;
                nack_req_ff <= pwdata[`HTWRP_CMD_NACK_BIT];
                txsh_ff <= tx_ff;
                case (pwdata[2:0])
                    `HTWRP_CMD_START: op_ff <= HTWRP_OP_START;
                    `HTWRP_CMD_STOP: op_ff <= HTWRP_OP_STOP;
                    `HTWRP_CMD_WRITE: op_ff <= HTWRP_OP_BYTE;
                    `HTWRP_CMD_READ: op_ff <= HTWRP_OP_BYTE;
                    default: op_ff <= HTWRP_OP_IDLE;
                endcase
            end
        end else if (tick) begin
            phase_ff <= phase_ff + 2'd1;
            case (op_ff)
                HTWRP_OP_START: begin
                    case (phase_ff)
                        2'd0: sda_low_ff <= 1'b0;
                        2'd1: clk_ff <= 1'b1;
                        2'd2: sda_low_ff <= 1'b1;
                        default: begin
                            clk_ff <= 1'b0;
                            op_ff <= HTWRP_OP_IDLE;
                        end
                    endcase
                end
                HTWRP_OP_STOP: begin
                    case (phase_ff)
                        2'd0: sda_low_ff <= 1'b1;
                        2'd1: clk_ff <= 1'b1;
                        2'd2: sda_low_ff <= 1'b0;
                        default: op_ff <= HTWRP_OP_IDLE;
                    endcase
                end
                default: begin
                    case (phase_ff)
                        2'd0: begin
                            if (bitn_ff != `HTWRP_BITS_PER_BYTE) begin
                                sda_low_ff <= ~rd_ff & ~txsh_ff[7]; // RULE1
                            end else begin
                                sda_low_ff <= rd_ff & ~nack_req_ff;
                            end
                        end
                        2'd1: clk_ff <= 1'b1;
                        2'd2: begin
                            if (bitn_ff != `HTWRP_BITS_PER_BYTE) begin
                                rxsh_ff <= {rxsh_ff[6:0], sda_s[0]}; // RULE1
                            end else if (rd_ff) begin
                                rx_ff <= rxsh_ff;
                            end else begin
                                nack_ff <= sda_s[0];
                            end
                        end
                        default: begin
                            clk_ff <= 1'b0;
                            txsh_ff <= {txsh_ff[6:0], 1'b0};
                            bitn_ff <= bitn_ff + 4'd1;
                            if (bitn_ff == `HTWRP_BITS_PER_BYTE) begin
                                op_ff <= HTWRP_OP_IDLE;
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    assign link.host_clk = clk_ff;
    assign link.host_data_out = 1'b0;
    assign link.host_data_oe_n = ~sda_low_ff;
endmodule

`default_nettype wire

/* File: sim/htwrp_asserts.sv */
`timescale 1ns/1ns
`default_nettype none

module htwrp_asserts #(
    parameter int QUARTER = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic host_clk,
    input wire logic host_data_oe_n,
    input wire logic dev_data_out,
    input wire logic dev_data_oe_n,
    input wire logic data_line
);
    logic [31:0] run_ff;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Length of the present link clock level, in cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_ff <= 32'h0;
        else if ($changed(host_clk))
            run_ff <= 32'h1;
        else
            run_ff <= run_ff + 32'h1;
    end

    sequence start_s;
        host_clk && $past(host_clk) && $fell(data_line);
    endsequence

    sequence stop_s;
        host_clk && $past(host_clk) && $rose(data_line);
    endsequence

    a_dev_open_drain: assert property (dev_data_out == 1'b0)
        else $error("device drove the data line high");
    // A device edge while the clock is high would read as start or stop
    a_dev_data_stable: assert property
        (host_clk && $past(host_clk) |-> $stable(dev_data_oe_n))
        else $error("device data moved while link clock high");
    a_start_by_host: assert property (start_s |-> !host_data_oe_n)
        else $error("start not made by the host");
    a_start_clk_hold: assert property (start_s |-> host_clk [*3])
        else $error("start hold too short");
    a_stop_release: assert property (stop_s |-> dev_data_oe_n [*4])
        else $error("device pulled the line after stop");
    a_clk_high_len: assert property
        ($fell(host_clk) |-> run_ff >= 2 * QUARTER)
        else $error("link clock high phase too short");
    a_clk_low_len: assert property
        ($rose(host_clk) |-> run_ff >= QUARTER)
        else $error("link clock low phase too short");
    a_reset_idle: assert property ($rose(presetn) |->
        host_clk && host_data_oe_n && dev_data_oe_n)
        else $error("link not idle after reset");
endmodule

`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import htwrp_pkg::*;

    typedef struct packed {
        htwrp_byte_t p;
        htwrp_byte_t d;
    } htwrp_row_s;

    localparam int Q = 4;
    localparam htwrp_row_s ROWS [3] = '{
        '{8'h10, 8'ha5}, '{8'hfd, 8'h3c}, '{8'h60, 8'h5a}};

    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [4:0] address_strap_inputs;
    logic tuner_clk_src, tuner_data_src, general_port_line_one_in;
    logic [1:0] gp_out, gp_oe_n;
    logic general_port_line_zero_out, general_port_line_zero_oe_n;
    logic general_port_line_one_out, general_port_line_one_oe_n;
    logic tuner_data_in, tuner_master_mode;
    logic [6:0] bus_address;
    logic [8:0] sh;
    htwrp_byte_t register_pointer, adw;
    int mismatches = 0, n_checks = 0, cyc = 0;

    htwrp_if link();

    htwrp_host #(.QUARTER(Q)) htwrp_host_i (.pclk, .presetn, .link,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);
    htwrp_device htwrp_device_i (.pclk, .presetn, .link,
        .address_strap_inputs, .tuner_clk_src, .tuner_data_src, .gp_out,
        .gp_oe_n, .general_port_line_one_in, .general_port_line_zero_out,
        .general_port_line_zero_oe_n, .general_port_line_one_out,
        .general_port_line_one_oe_n, .tuner_data_in, .tuner_master_mode,
        .register_pointer, .bus_address);
    htwrp_asserts #(.QUARTER(Q)) htwrp_asserts_i (.pclk, .presetn,
        .host_clk(link.host_clk), .host_data_oe_n(link.host_data_oe_n),
        .dev_data_out(link.dev_data_out),
        .dev_data_oe_n(link.dev_data_oe_n), .data_line(link.data_line));

    always #5 pclk = ~pclk;

    // Wire view: the last nine bits are eight data bits and the ack
    always @(posedge link.host_clk) sh <= {sh[7:0], link.data_line};

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task summarize;
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Busy polling leaves the status word in r
    task automatic op(input logic [3:0] c, input logic [7:0] d);
        apb(1'b1, 8'h04, d);
        apb(1'b1, 8'h00, {4'h0, c});
        do apb(1'b0, 8'h0c, 8'h00); while (r[0] !== 1'b0);
    endtask

    task automatic st;
        op(4'h1, 8'h00);
    endtask

    task automatic sp;
        op(4'h2, 8'h00);
    endtask

    task automatic wr(input logic [7:0] d, input logic nk);
        op(4'h3, d);
        chk(sh[8:1], d);
        chk({7'h0, r[1]}, {7'h0, nk});
    endtask

    task automatic rd(input logic nk, input logic [7:0] e);
        op({nk, 3'h4}, 8'h00);
        apb(1'b0, 8'h08, 8'h00);
        chk(r[7:0], e);
        chk(sh[8:1], e);
    endtask

    task automatic seek(input logic [7:0] p);
        st();
        wr(adw, 1'b0);
        wr(p, 1'b0);
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        address_strap_inputs = 5'h1a;
        {tuner_clk_src, tuner_data_src, general_port_line_one_in} = 3'b010;
        gp_out = 2'b01;
        gp_oe_n = 2'b10;
        adw = 8'h34;
        // Scaled-down stand-in for the long power-up hold
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        // Straps move after the latch point and must be ignored
        address_strap_inputs <= 5'h05;
        repeat (4) @(posedge pclk);
        chk({1'b0, bus_address}, 8'h1a);
        chk(register_pointer, 8'h00);
        foreach (ROWS[i]) begin
            seek(ROWS[i].p);
            wr(ROWS[i].d, 1'b0);
            wr(~ROWS[i].d, 1'b0);
            sp();
            chk(register_pointer, 8'h00);
            seek(ROWS[i].p);
            st();
            wr(adw | 8'h01, 1'b0);
            rd(1'b0, ROWS[i].d);
            chk(register_pointer, ROWS[i].p + 8'h01);
            rd(1'b1, ~ROWS[i].d);
            sp();
        end
        seek(8'h00);
        wr(8'h77, 1'b0);
        sp();
        st();
        wr(adw | 8'h01, 1'b0);
        rd(1'b1, 8'h77);
        sp();
        seek(8'h20);
        st();
        wr(adw | 8'h01, 1'b0);
        rd(1'b1, 8'h00);
        st();
        wr(adw, 1'b0);
        wr(8'h99, 1'b0);
        sp();
        seek(8'h21);
        st();
        wr(adw | 8'h01, 1'b0);
        rd(1'b1, 8'h99);
        // A foreign message between pointer set and read must not land
        seek(8'h40);
        st();
        wr(adw ^ 8'h02, 1'b1);
        wr(8'h55, 1'b1);
        st();
        wr(adw | 8'h01, 1'b0);
        rd(1'b1, 8'h00);
        sp();
        seek(8'h62);
        wr(8'h08, 1'b0);
        sp();
        tuner_clk_src <= 1'b1;
        general_port_line_one_in <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({7'h0, tuner_master_mode}, 8'h01);
        chk({6'h0, general_port_line_zero_oe_n,
             general_port_line_zero_out}, 8'h01);
        chk({5'h0, general_port_line_one_out, general_port_line_one_oe_n,
             tuner_data_in}, 8'h03);
        apb(1'b0, 8'h10, 8'h00);
        chk({7'h0, pslverr}, 8'h01);
        chk(r[7:0], 8'h00);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({1'b0, bus_address}, 8'h05);
        chk({7'h0, tuner_master_mode}, 8'h00);
        chk({4'h0, general_port_line_one_oe_n, general_port_line_one_out,
             general_port_line_zero_oe_n,
             general_port_line_zero_out}, 8'h09);
        chk(register_pointer, 8'h00);
        st();
        wr(8'h34, 1'b1);
        st();
        wr(8'h0a, 1'b0);
        sp();
        summarize();
    end
endmodule

`default_nettype wire
